// ---- verilog/fgp_port.sv ----
// Fast GPIO port register block on the core single-cycle alias
`timescale 1ns/1ps
// What this block does
// - Output level bit drives its pin when the pin is a GPIO output.
// - Output level bits of unimplemented pins always read zero.
// - Set register write forces ones where written bits are one.
// - Clear register write forces zeros where written bits are one.
// - Toggle register write inverts bits where written bits are one.
// - Input level returns pin level; zero if unimplemented or not digital.
// - Input level holds while the port control module is disabled.
// - Direction zero makes a GPIO pin input, one makes it output.
// - Input pin with disabled input path is left high impedance.
// - Input disable one blocks input and reads zero; zero enables it.
// - One set, clear or toggle write may change many bits at once.
// - Direction and output registers update even with port control disabled.
// - Registers are reachable at the fast alias base address.
// - Valid alias accesses complete in a single cycle.
// - Out-of-map accesses error with one wait state; valid ones take none.
module fgp_port #(
	parameter logic [31:0] PORT_INDEX = 32'h0000_0000,
	parameter logic [31:0] PIN_MASK   = fgp_pkg::RST_PIN_MASK
) (
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	input  wire logic        bus_sel_i,
	input  wire logic        bus_write_i,
	input  wire logic [31:0] bus_addr_i,
	input  wire logic [31:0] bus_wdata_i,
	output logic      [31:0] bus_rdata_o,
	output logic             bus_ready_o,
	output logic             bus_error_o,
	input  wire logic [31:0] gpio_sel_i,
	input  wire logic [31:0] digital_sel_i,
	input  wire logic        port_en_i,
	input  wire logic [31:0] pin_i,
	output logic      [31:0] pin_o,
	output logic      [31:0] pin_oe_o
);
	localparam logic [31:0] PORT_BASE =
		32'(fgp_pkg::ALIAS_BASE + fgp_pkg::PORT_STRIDE * PORT_INDEX);

	logic [31:0] output_level_reg;
	logic [31:0] output_level_next;
	logic [31:0] direction_reg;
	logic [31:0] input_disable_reg;
	logic [31:0] input_level_w;
	logic        hit_port;
	logic        map_ok;
	logic [5:0]  offset;
	logic        wr_ok;
	logic        rd_ok;
	fgp_pkg::fgp_bus_state_e state_reg;

	// Address decode within this port window
	assign offset   = bus_addr_i[5:0];
	assign hit_port = bus_sel_i && (bus_addr_i[31:6] == PORT_BASE[31:6]);
	always_comb begin
		map_ok = 1'b0;
		if (bus_addr_i[1:0] == 2'b00) begin
			case (offset)
				fgp_pkg::OFS_OUTPUT_LEVEL,
				fgp_pkg::OFS_OUTPUT_SET,
				fgp_pkg::OFS_OUTPUT_CLEAR,
				fgp_pkg::OFS_OUTPUT_TOGGLE,
				fgp_pkg::OFS_INPUT_LEVEL,
				fgp_pkg::OFS_DIRECTION,
				fgp_pkg::OFS_INPUT_DISABLE: map_ok = 1'b1;
				default: map_ok = 1'b0;
			endcase
		end
	end
	assign wr_ok = hit_port && map_ok && bus_write_i && (state_reg == fgp_pkg::FGP_IDLE);
	assign rd_ok = hit_port && map_ok && !bus_write_i && (state_reg == fgp_pkg::FGP_IDLE);

	// Output level next value from direct, set, clear, toggle writes
	always_comb begin
		output_level_next = output_level_reg;
		if (wr_ok) begin
			case (offset)
				fgp_pkg::OFS_OUTPUT_LEVEL: output_level_next = bus_wdata_i;
				fgp_pkg::OFS_OUTPUT_SET: output_level_next = output_level_reg | bus_wdata_i;
				fgp_pkg::OFS_OUTPUT_CLEAR: output_level_next = output_level_reg & ~bus_wdata_i;
				fgp_pkg::OFS_OUTPUT_TOGGLE: output_level_next = output_level_reg ^ bus_wdata_i;
				default: output_level_next = output_level_reg;
			endcase
		end
	end

	// Output level register, unimplemented bits held at zero
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			output_level_reg <= fgp_pkg::RST_OUTPUT_LEVEL;
		end else begin
			output_level_reg <= output_level_next & PIN_MASK;
		end
	end

	// Direction register
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			direction_reg <= fgp_pkg::RST_DIRECTION;
		end else if (wr_ok && offset == fgp_pkg::OFS_DIRECTION) begin
			direction_reg <= bus_wdata_i & PIN_MASK;
		end
	end

	// Input disable register
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			input_disable_reg <= fgp_pkg::RST_INPUT_DISABLE;
		end else if (wr_ok && offset == fgp_pkg::OFS_INPUT_DISABLE) begin
			input_disable_reg <= bus_wdata_i;
		end
	end

	// Per-pin drive and input sampling
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_pin
			fgp_pin_cell u_cell (
				.clock_i       (clock_i),
				.srst_i        (srst_i),
				.impl_i        (PIN_MASK[gi]),
				.gpio_sel_i    (gpio_sel_i[gi]),
				.digital_sel_i (digital_sel_i[gi]),
				.dir_i         (direction_reg[gi]),
				.out_lvl_i     (output_level_reg[gi]),
				.in_dis_i      (input_disable_reg[gi]),
				.port_en_i     (port_en_i),
				.pin_i         (pin_i[gi]),
				.in_lvl_o      (input_level_w[gi]),
				.pin_o         (pin_o[gi]),
				.pin_oe_o      (pin_oe_o[gi])
			);
		end
	endgenerate

	// Bus answer: registered ready in the next cycle, error after one wait
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_reg   <= fgp_pkg::FGP_IDLE;
			bus_ready_o <= 1'b0;
			bus_error_o <= 1'b0;
			bus_rdata_o <= 32'h0000_0000;
		end else begin
			bus_ready_o <= 1'b0;
			bus_error_o <= 1'b0;
			bus_rdata_o <= 32'h0000_0000;
			case (state_reg)
				fgp_pkg::FGP_IDLE: begin
					if (hit_port && map_ok) begin
						bus_ready_o <= 1'b1;
						if (!bus_write_i) begin
							case (offset)
								fgp_pkg::OFS_OUTPUT_LEVEL: bus_rdata_o <= output_level_reg;
								fgp_pkg::OFS_INPUT_LEVEL: bus_rdata_o <= input_level_w;
								fgp_pkg::OFS_DIRECTION: bus_rdata_o <= direction_reg;
								fgp_pkg::OFS_INPUT_DISABLE: bus_rdata_o <= input_disable_reg;
								default: bus_rdata_o <= 32'h0000_0000;
							endcase
						end
					end else if (hit_port) begin
						state_reg <= fgp_pkg::FGP_ERR;
					end
				end
				fgp_pkg::FGP_ERR: begin
					bus_ready_o <= 1'b1;
					bus_error_o <= 1'b1;
					state_reg   <= fgp_pkg::FGP_IDLE;
				end
				default: state_reg <= fgp_pkg::FGP_IDLE;
			endcase
		end
	end

	// Checks on register updates, pins and bus timing

	// Set write raises every implemented bit written as one
	chk_set_bits: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_OUTPUT_SET
		|=> (output_level_reg & $past(bus_wdata_i & PIN_MASK)) == $past(bus_wdata_i & PIN_MASK))
		else $error("set write left a bit low");

	// Set write leaves bits written as zero alone
	chk_set_keeps: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_OUTPUT_SET
		|=> ((output_level_reg ^ $past(output_level_reg)) & ~$past(bus_wdata_i)) == 32'h0000_0000)
		else $error("set write moved a bit written as zero");

	// Clear write drops every bit written as one
	chk_clear_bits: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_OUTPUT_CLEAR
		|=> (output_level_reg & $past(bus_wdata_i)) == 32'h0000_0000)
		else $error("clear write left a bit high");

	// Clear write leaves bits written as zero alone
	chk_clear_keeps: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_OUTPUT_CLEAR
		|=> ((output_level_reg ^ $past(output_level_reg)) & ~$past(bus_wdata_i)) == 32'h0000_0000)
		else $error("clear write moved a bit written as zero");

	// Toggle write inverts exactly the implemented bits written as one
	chk_toggle_bits: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_OUTPUT_TOGGLE
		|=> output_level_reg == ($past(output_level_reg ^ bus_wdata_i) & PIN_MASK))
		else $error("toggle write wrong");

	// Write-only views answer reads with zero
	chk_views_read0: assert property (@(posedge clock_i) disable iff (srst_i)
		rd_ok && (offset == fgp_pkg::OFS_OUTPUT_SET || offset == fgp_pkg::OFS_OUTPUT_CLEAR
			|| offset == fgp_pkg::OFS_OUTPUT_TOGGLE)
		|=> bus_rdata_o == 32'h0000_0000)
		else $error("write-only view read nonzero");

	// Missing pins never hold an output level
	chk_unimpl_zero: assert property (@(posedge clock_i) disable iff (srst_i)
		1'b1
		|-> (output_level_reg & ~PIN_MASK) == 32'h0000_0000)
		else $error("unimplemented output bit set");

	// Direct level write lands on implemented pins
	chk_level_write: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_OUTPUT_LEVEL
		|=> output_level_reg == $past(bus_wdata_i & PIN_MASK))
		else $error("level write did not land");

	// Output level moves only on a register write
	chk_level_hold: assert property (@(posedge clock_i) disable iff (srst_i)
		!wr_ok
		|=> $stable(output_level_reg))
		else $error("output level moved with no write");

	// Pin drive value follows the output level
	chk_pin_level: assert property (@(posedge clock_i) disable iff (srst_i)
		1'b1
		|=> pin_o == $past(output_level_reg))
		else $error("pin drive value wrong");

	// Writes still land while port control is off
	chk_write_off: assert property (@(posedge clock_i) disable iff (srst_i)
		!port_en_i && wr_ok && offset == fgp_pkg::OFS_OUTPUT_LEVEL
		|=> output_level_reg == $past(bus_wdata_i & PIN_MASK))
		else $error("write lost while port off");

	// Drive enable only for GPIO pins set as outputs
	chk_drive_out: assert property (@(posedge clock_i) disable iff (srst_i)
		1'b1
		|=> pin_oe_o == $past(gpio_sel_i & direction_reg & PIN_MASK))
		else $error("output enable wrong");

	// Direction write lands on implemented pins
	chk_dir_write: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_DIRECTION
		|=> direction_reg == $past(bus_wdata_i & PIN_MASK))
		else $error("direction write did not land");

	// Input pins are never driven
	chk_input_dir: assert property (@(posedge clock_i) disable iff (srst_i)
		1'b1
		|=> (pin_oe_o & ~$past(direction_reg)) == 32'h0000_0000)
		else $error("input pin driven");

	// Disabled input path reads zero
	chk_disabled_in: assert property (@(posedge clock_i) disable iff (srst_i)
		port_en_i
		|=> (input_level_w & $past(input_disable_reg)) == 32'h0000_0000)
		else $error("disabled input read nonzero");

	// Input disable write lands as written
	chk_dis_write: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_ok && offset == fgp_pkg::OFS_INPUT_DISABLE
		|=> input_disable_reg == $past(bus_wdata_i))
		else $error("input disable write did not land");

	// Enabled input follows the qualified pin level
	chk_input_sample: assert property (@(posedge clock_i) disable iff (srst_i)
		port_en_i
		|=> input_level_w == $past(pin_i & digital_sel_i & PIN_MASK & ~input_disable_reg))
		else $error("input sample wrong");

	// Pins with no digital function read zero
	chk_not_digital: assert property (@(posedge clock_i) disable iff (srst_i)
		port_en_i
		|=> (input_level_w & ~$past(digital_sel_i)) == 32'h0000_0000)
		else $error("non-digital pin read nonzero");

	// Missing pins read zero on the input side
	chk_unimpl_in: assert property (@(posedge clock_i) disable iff (srst_i)
		1'b1
		|-> (input_level_w & ~PIN_MASK) == 32'h0000_0000)
		else $error("unimplemented input bit set");

	// Input read returns the registered input level
	chk_read_input: assert property (@(posedge clock_i) disable iff (srst_i)
		rd_ok && offset == fgp_pkg::OFS_INPUT_LEVEL
		|=> bus_rdata_o == $past(input_level_w))
		else $error("input read data wrong");

	// Input level frozen while port control is off
	chk_input_hold: assert property (@(posedge clock_i) disable iff (srst_i)
		!port_en_i
		|=> $stable(input_level_w))
		else $error("input level moved while port off");

	// Requests outside this port window get no answer
	chk_window_only: assert property (@(posedge clock_i) disable iff (srst_i)
		!hit_port && state_reg == fgp_pkg::FGP_IDLE
		|=> !bus_ready_o)
		else $error("answer outside port window");

	// Valid access answers in the next cycle, no error
	chk_valid_nowait: assert property (@(posedge clock_i) disable iff (srst_i)
		hit_port && map_ok && state_reg == fgp_pkg::FGP_IDLE
		|=> bus_ready_o && !bus_error_o)
		else $error("valid access not single cycle");

	// Read data bus idles at zero
	chk_rdata_quiet: assert property (@(posedge clock_i) disable iff (srst_i)
		!bus_ready_o
		|-> bus_rdata_o == 32'h0000_0000)
		else $error("read data without ready");

	// Level read returns the register as it stood
	chk_read_level: assert property (@(posedge clock_i) disable iff (srst_i)
		rd_ok && offset == fgp_pkg::OFS_OUTPUT_LEVEL
		|=> bus_rdata_o == $past(output_level_reg))
		else $error("level read data wrong");

	// Bad access: one wait cycle, then ready with error
	chk_err_wait: assert property (@(posedge clock_i) disable iff (srst_i)
		hit_port && !map_ok && state_reg == fgp_pkg::FGP_IDLE
		|=> !bus_ready_o ##1 bus_ready_o && bus_error_o)
		else $error("bad access error timing");

	// Error state always answers and returns to idle
	chk_err_answer: assert property (@(posedge clock_i) disable iff (srst_i)
		state_reg == fgp_pkg::FGP_ERR
		|=> bus_ready_o && bus_error_o && state_reg == fgp_pkg::FGP_IDLE)
		else $error("error state did not answer");

	// Error is a single pulse that comes with ready
	chk_err_pulse: assert property (@(posedge clock_i) disable iff (srst_i)
		bus_error_o
		|-> bus_ready_o ##1 !bus_error_o)
		else $error("error pulse malformed");

	// Registers and outputs at their reset values after reset
	chk_reset_values: assert property (@(posedge clock_i) disable iff (srst_i)
		$past(srst_i)
		|-> output_level_reg == fgp_pkg::RST_OUTPUT_LEVEL && direction_reg == fgp_pkg::RST_DIRECTION
			&& input_disable_reg == fgp_pkg::RST_INPUT_DISABLE && pin_oe_o == 32'h0000_0000)
		else $error("reset values wrong");

	cov_set: cover property (@(posedge clock_i) wr_ok && offset == fgp_pkg::OFS_OUTPUT_SET);
	cov_toggle: cover property (@(posedge clock_i) wr_ok && offset == fgp_pkg::OFS_OUTPUT_TOGGLE);
	cov_error: cover property (@(posedge clock_i) bus_error_o);
	cov_hold: cover property (@(posedge clock_i) !port_en_i ##1 !port_en_i);
endmodule

// ---- verilog/fgp_pkg.sv ----
// Package with register map, reset values and timing for the fast GPIO port
package fgp_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 32;
	localparam logic [31:0] ALIAS_BASE = 32'hf800_0000;
	localparam logic [31:0] PORT_STRIDE = 32'h0000_0040;
	localparam logic [5:0] OFS_OUTPUT_LEVEL = 6'h00;
	localparam logic [5:0] OFS_OUTPUT_SET = 6'h04;
	localparam logic [5:0] OFS_OUTPUT_CLEAR = 6'h08;
	localparam logic [5:0] OFS_OUTPUT_TOGGLE = 6'h0c;
	localparam logic [5:0] OFS_INPUT_LEVEL = 6'h10;
	localparam logic [5:0] OFS_DIRECTION = 6'h14;
	localparam logic [5:0] OFS_INPUT_DISABLE = 6'h18;
	localparam logic [31:0] RST_OUTPUT_LEVEL = 32'h0000_0000;
	localparam logic [31:0] RST_DIRECTION = 32'h0000_0000;
	localparam logic [31:0] RST_INPUT_DISABLE = 32'hffff_ffff;
	localparam logic [31:0] RST_INPUT_LEVEL = 32'h0000_0000;
	localparam logic [31:0] RST_PIN_MASK = 32'hffff_ffff;
	localparam int unsigned ERR_WAIT_CYCLES = 1;
	typedef enum logic [1:0] {
		FGP_IDLE = 2'b00,
		FGP_ERR = 2'b01
	} fgp_bus_state_e;
endpackage

// ---- verilog/fgp_pin_cell.sv ----
// One pin's drive and input-path qualification
`timescale 1ns/1ps
module fgp_pin_cell (
	input  wire logic clock_i,
	input  wire logic srst_i,
	input  wire logic impl_i,
	input  wire logic gpio_sel_i,
	input  wire logic digital_sel_i,
	input  wire logic dir_i,
	input  wire logic out_lvl_i,
	input  wire logic in_dis_i,
	input  wire logic port_en_i,
	input  wire logic pin_i,
	output logic      in_lvl_o,
	output logic      pin_o,
	output logic      pin_oe_o
);
	logic in_lvl_reg;
	logic in_lvl_next;

	// Input sample; held while port control is off
	always_comb begin
		in_lvl_next = in_lvl_reg;
		if (port_en_i) begin
			in_lvl_next = pin_i & impl_i & digital_sel_i & ~in_dis_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			in_lvl_reg <= 1'b0;
		end else begin
			in_lvl_reg <= in_lvl_next;
		end
	end

	// Pin drive: output from level register when GPIO output
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			pin_o    <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_o    <= out_lvl_i;
			pin_oe_o <= impl_i & gpio_sel_i & dir_i;
		end
	end

	assign in_lvl_o = in_lvl_reg;
endmodule

// ---- tb/fgp_pin_model.sv ----
// Pin model: outside levels plus read back of driven pins
`timescale 1ns/1ps
module fgp_pin_model (
	input  wire logic [31:0] pin_o_i,
	input  wire logic [31:0] pin_oe_i,
	input  wire logic [31:0] ext_lvl_i,
	output logic      [31:0] pin_lvl_o
);
	// Driven pins show the drive value, released pins the outside level
	assign pin_lvl_o = (pin_o_i & pin_oe_i) | (ext_lvl_i & ~pin_oe_i);
endmodule

// ---- tb/fgp_port_tb.sv ----
// Self-checking testbench for the fast GPIO port
`timescale 1ns/1ps
module fgp_port_tb;
	localparam logic [31:0] M = 32'hefff_ffff; // Pin 28 not implemented
	logic        clock_i = 1'b0;
	logic        srst_i  = 1'b1;
	logic        sel     = 1'b0;
	logic        wr      = 1'b0;
	logic        en      = 1'b1;
	logic        rdy;
	logic        err;
	logic        erv;
	logic [31:0] addr = 32'h0;
	logic [31:0] wd   = 32'h0;
	logic [31:0] gsel = 32'hffff_ffff;
	logic [31:0] dsel = 32'hffff_ff7f;
	logic [31:0] ext  = 32'h0;
	logic [31:0] rd, rdata, pin_i, pin_o, pin_oe;
	int          fail_count = 0;
	int          n_checks = 0;
	int          lat, lat_ok;
	// Free-running clock
	always #2.5 clock_i = ~clock_i;
	fgp_port #(.PIN_MASK(M)) uut (.clock_i(clock_i), .srst_i(srst_i), .bus_sel_i(sel),
		.bus_write_i(wr), .bus_addr_i(addr), .bus_wdata_i(wd), .bus_rdata_o(rdata),
		.bus_ready_o(rdy), .bus_error_o(err), .gpio_sel_i(gsel), .digital_sel_i(dsel),
		.port_en_i(en), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe));
	fgp_pin_model pins (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_lvl_i(ext),
		.pin_lvl_o(pin_i));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(string what, logic [31:0] got, logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One access, then a bounded wait for the answer
	task automatic acc(logic w, logic [5:0] ofs, logic [31:0] d);
		@(posedge clock_i);
		#1;
		sel = 1'b1;
		wr = w;
		addr = fgp_pkg::ALIAS_BASE + {26'h0, ofs};
		wd = d;
		@(posedge clock_i);
		#1;
		sel = 1'b0;
		lat = 0;
		while (rdy !== 1'b1 && lat < 4) begin
			@(posedge clock_i);
			#1;
			lat++;
		end
		if (rdy !== 1'b1) begin
			fail_count++;
			print_verdict();
		end else begin
			rd = rdata;
			erv = err;
		end
	endtask
	task automatic wait_cyc(int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic t_reset();
		acc(1'b0, fgp_pkg::OFS_OUTPUT_LEVEL, 32'h0);
		lat_ok = lat;
		check("err", {31'h0, erv}, 32'h0);
		check("out", rd, 32'h0);
		acc(1'b0, fgp_pkg::OFS_DIRECTION, 32'h0);
		check("dir", rd, 32'h0);
		acc(1'b0, fgp_pkg::OFS_INPUT_DISABLE, 32'h0);
		check("dis", rd, 32'hffff_ffff);
		check("oe", pin_oe, 32'h0);
		$display("done reset");
	endtask
	task automatic t_bits();
		en = 1'b0;
		acc(1'b1, fgp_pkg::OFS_OUTPUT_LEVEL, 32'h0000_0f0f);
		acc(1'b1, fgp_pkg::OFS_OUTPUT_SET, 32'hf000_0000);
		acc(1'b1, fgp_pkg::OFS_OUTPUT_CLEAR, 32'h0000_0003);
		acc(1'b1, fgp_pkg::OFS_OUTPUT_TOGGLE, 32'h00ff_0001);
		acc(1'b0, fgp_pkg::OFS_OUTPUT_LEVEL, 32'h0);
		check("out", rd, 32'hf0ff_0f0d & M);
		acc(1'b0, fgp_pkg::OFS_OUTPUT_SET, 32'h0);
		check("set", rd, 32'h0);
		en = 1'b1;
		$display("done bits");
	endtask
	task automatic t_drive();
		gsel = 32'h7fff_ffff;
		acc(1'b1, fgp_pkg::OFS_DIRECTION, 32'hffff_0000);
		wait_cyc(2);
		check("oe", pin_oe, 32'h7fff_0000 & M);
		check("pin", pin_o & pin_oe, 32'h70ff_0000 & M);
		$display("done drive");
	endtask
	task automatic t_input();
		ext = 32'h0000_00f5;
		acc(1'b1, fgp_pkg::OFS_INPUT_DISABLE, 32'hffff_ff0f);
		wait_cyc(2);
		acc(1'b0, fgp_pkg::OFS_INPUT_LEVEL, 32'h0);
		check("in", rd, 32'h0000_0070);
		en = 1'b0;
		ext = 32'h0;
		wait_cyc(2);
		acc(1'b0, fgp_pkg::OFS_INPUT_LEVEL, 32'h0);
		check("in held", rd, 32'h0000_0070);
		en = 1'b1;
		wait_cyc(2);
		acc(1'b0, fgp_pkg::OFS_INPUT_LEVEL, 32'h0);
		check("in live", rd, 32'h0);
		$display("done input");
	endtask
	task automatic t_error();
		acc(1'b0, 6'h1c, 32'h0);
		check("err", {31'h0, erv}, 32'h1);
		check("wait", lat, lat_ok + 1);
		acc(1'b1, 6'h02, 32'h1);
		check("err", {31'h0, erv}, 32'h1);
		$display("done error");
	endtask
	// Write aimed at the next port window must be ignored
	task automatic t_window();
		logic seen;
		seen = 1'b0;
		@(posedge clock_i);
		#1;
		sel = 1'b1;
		wr = 1'b1;
		addr = fgp_pkg::ALIAS_BASE + fgp_pkg::PORT_STRIDE + {26'h0, fgp_pkg::OFS_OUTPUT_SET};
		wd = 32'hffff_ffff;
		@(posedge clock_i);
		#1;
		sel = 1'b0;
		repeat (3) begin
			if (rdy !== 1'b0) begin
				seen = 1'b1;
			end
			@(posedge clock_i);
			#1;
		end
		check("window", {31'h0, seen}, 32'h0);
		acc(1'b0, fgp_pkg::OFS_OUTPUT_LEVEL, 32'h0);
		check("window out", rd, 32'hf0ff_0f0d & M);
		$display("done window");
	endtask
	// Reset in mid-run with the output level, direction and input disable registers away from their reset values
	task automatic t_rerun();
		@(posedge clock_i);
		#1;
		srst_i = 1'b1;
		wait_cyc(2);
		srst_i = 1'b0;
		check("oe", pin_oe, 32'h0);
		acc(1'b0, fgp_pkg::OFS_DIRECTION, 32'h0);
		check("dir", rd, 32'h0);
		acc(1'b0, fgp_pkg::OFS_INPUT_DISABLE, 32'h0);
		check("dis", rd, 32'hffff_ffff);
		acc(1'b0, fgp_pkg::OFS_OUTPUT_LEVEL, 32'h0);
		check("out", rd, 32'h0);
		$display("done rerun");
	endtask
	initial begin
		repeat (10) @(posedge clock_i);
		#1;
		srst_i = 1'b0;
		t_reset();
		t_bits();
		t_window();
		t_drive();
		t_input();
		t_error();
		t_rerun();
		print_verdict();
	end
endmodule
